// *** rtl/cmd_decoder_pkg.sv ***
// Purpose: Shared constants and types for the direct command decoder
// Assumes: Commands arrive as single bytes with a one-cycle valid strobe
// Notes: Codes and enable requirements follow the command table
package cmd_decoder_pkg;

	localparam logic [7:0] CMD_SET_DEFAULT_A = 8'hC0;
	localparam logic [7:0] CMD_SET_DEFAULT_B = 8'hC1;
	localparam logic [7:0] CMD_STOP_ALL_A = 8'hC2;
	localparam logic [7:0] CMD_STOP_ALL_B = 8'hC3;
	localparam logic [7:0] CMD_TX_CRC = 8'hC4;
	localparam logic [7:0] CMD_TX_NOCRC = 8'hC5;
	localparam logic [7:0] CMD_TX_REQA = 8'hC6;
	localparam logic [7:0] CMD_TX_WUPA = 8'hC7;
	localparam logic [7:0] CMD_FIELD_INIT = 8'hC8;
	localparam logic [7:0] CMD_FIELD_RESP = 8'hC9;
	localparam logic [7:0] CMD_GO_SENSE = 8'hCD;
	localparam logic [7:0] CMD_GO_SLEEP = 8'hCE;
	localparam logic [7:0] CMD_MASK_RX = 8'hD0;
	localparam logic [7:0] CMD_UNMASK_RX = 8'hD1;
	localparam logic [7:0] CMD_AM_TOGGLE = 8'hD2;
	localparam logic [7:0] CMD_MEAS_AMP = 8'hD3;
	localparam logic [7:0] CMD_RX_GAIN = 8'hD5;
	localparam logic [7:0] CMD_ADJ_REG = 8'hD6;
	localparam logic [7:0] CMD_CAL_DRV = 8'hD8;
	localparam logic [7:0] CMD_MEAS_PHASE = 8'hD9;
	localparam logic [7:0] CMD_CLR_RSSI = 8'hDA;
	localparam logic [7:0] CMD_CLR_FIFO = 8'hDB;
	localparam logic [7:0] CMD_TRANSPARENT = 8'hDC;
	localparam logic [7:0] CMD_CAL_CAP = 8'hDD;
	localparam logic [7:0] CMD_MEAS_CAP = 8'hDE;
	localparam logic [7:0] CMD_MEAS_SUPPLY = 8'hDF;
	localparam logic [7:0] CMD_TMR_GP = 8'hE0;
	localparam logic [7:0] CMD_TMR_WAKE = 8'hE1;
	localparam logic [7:0] CMD_TMR_MASK = 8'hE2;
	localparam logic [7:0] CMD_TMR_NORESP = 8'hE3;
	localparam logic [7:0] CMD_TMR_PP2 = 8'hE4;
	localparam logic [7:0] CMD_TMR_NORESP_STOP = 8'hE8;
	localparam logic [7:0] CMD_SPACE_B = 8'hFB;
	localparam logic [7:0] CMD_TEST_ACCESS = 8'hFC;

	// Default busy time of a long-running command, in cycles
	localparam int EXEC_CYCLES_DEF = 16;

	// Enable requirement class of a command
	typedef enum logic [2:0] {
		REQ_ALL,
		REQ_EN,
		REQ_EN_TX,
		REQ_EN_RX,
		REQ_NOT_WU,
		REQ_NONE
	} req_t;

	// Operation-control enable bits
	typedef struct packed {
		logic main_en;
		logic rx_en;
		logic tx_en;
		logic wakeup_mode_bit;
	} op_ctrl_t;

	// One-cycle action strobes
	typedef struct packed {
		logic set_default;
		logic stop_all;
		logic tx_crc;
		logic tx_nocrc;
		logic tx_reqa;
		logic tx_wupa;
		logic field_init;
		logic field_resp;
		logic go_sense;
		logic go_sleep;
		logic rx_gain_reload;
		logic adjust_reg;
		logic cal_driver;
		logic meas_amp;
		logic meas_phase;
		logic clr_rssi;
		logic clr_fifo;
		logic transparent;
		logic cal_cap;
		logic meas_cap;
		logic meas_supply;
		logic tmr_gp;
		logic tmr_wake;
		logic tmr_mask;
		logic tmr_noresp;
		logic tmr_pp2;
		logic tmr_noresp_stop;
		logic test_access;
	} act_t;

	// Decode of one code
	typedef struct packed {
		logic known;
		logic chain;
		logic irq;
		logic timed;
		req_t req;
	} cmd_info_t;

endpackage

// *** rtl/cmd_table.sv ***
// Purpose: Combinational lookup of command properties
// Assumes: Pure function of the code byte
// Notes: Unknown and reserved codes return known = 0
module cmd_table
	import cmd_decoder_pkg::*;
(
	input wire logic [7:0] code,
	output cmd_info_t info
);

	always_comb begin
		info = '{known: 1'b1, chain: 1'b1, irq: 1'b0, timed: 1'b0, req: REQ_EN};
		unique case (code)
			CMD_SET_DEFAULT_A, CMD_SET_DEFAULT_B: begin
				info.chain = 1'b0;
				info.req = REQ_ALL;
			end
			CMD_STOP_ALL_A, CMD_STOP_ALL_B, CMD_TX_CRC, CMD_TX_NOCRC, CMD_CLR_RSSI,
			CMD_CLR_FIFO, CMD_TMR_GP, CMD_TMR_MASK, CMD_TMR_NORESP, CMD_TMR_PP2,
			CMD_TMR_NORESP_STOP: begin
				info.req = REQ_EN;
			end
			CMD_TX_REQA, CMD_TX_WUPA, CMD_AM_TOGGLE: begin
				info.req = REQ_EN_TX;
			end
			CMD_FIELD_INIT, CMD_FIELD_RESP: begin
				info.irq = 1'b1;
				info.timed = 1'b1;
			end
			CMD_GO_SENSE, CMD_GO_SLEEP: begin
				info.req = REQ_EN_RX;
			end
			CMD_MASK_RX, CMD_UNMASK_RX, CMD_SPACE_B, CMD_TEST_ACCESS: begin
				info.req = REQ_ALL;
			end
			CMD_MEAS_AMP, CMD_MEAS_PHASE, CMD_CAL_CAP, CMD_MEAS_CAP: begin
				info.chain = 1'b0;
				info.irq = 1'b1;
				info.timed = 1'b1;
				info.req = REQ_ALL;
			end
			CMD_ADJ_REG, CMD_MEAS_SUPPLY: begin
				info.chain = 1'b0;
				info.irq = 1'b1;
				info.timed = 1'b1;
			end
			CMD_RX_GAIN, CMD_CAL_DRV, CMD_TRANSPARENT: begin
				info.chain = 1'b0;
			end
			CMD_TMR_WAKE: begin
				info.req = REQ_NOT_WU;
			end
			default: begin
				info = '{known: 1'b0, chain: 1'b0, irq: 1'b0, timed: 1'b0, req: REQ_NONE};
			end
		endcase
	end

endmodule // cmd_table

// *** rtl/nfc_direct_command_decoder.sv ***
// Purpose: Decodes single-byte direct commands and dispatches their actions
// Assumes: CMD_VALID is a one-cycle strobe from the host interface, same clock
// Notes: Long commands hold BUSY and raise a completion pulse when done
module nfc_direct_command_decoder
	import cmd_decoder_pkg::*;
#(
	parameter int EXEC_CYCLES = EXEC_CYCLES_DEF
)
(
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_CODE,
	input wire op_ctrl_t OP_CTRL,
	input wire logic POWER_DOWN,
	input wire logic I2C_MODE,
	input wire logic I2C_STOP,
	input wire logic FRAME_END,
	output act_t ACTION,
	output logic CMD_ACCEPTED,
	output logic CMD_REFUSED,
	output logic CHAIN_OK,
	output logic BUSY,
	output logic DONE_IRQ,
	output logic OSC_TEMP_EN,
	output logic RX_MASKED,
	output logic AM_MODULATED,
	output logic TARGET_SLEEP,
	output logic SPACE_B_EN,
	output logic TEST_EN,
	output logic TRANSPARENT_MODE
);

	localparam int CNT_W = $clog2(EXEC_CYCLES + 1);
	localparam logic [CNT_W-1:0] EXEC_LOAD = CNT_W'(EXEC_CYCLES);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC
	} state_t;

	cmd_info_t info;
	logic req_met;
	logic accept;
	logic [7:0] code_r;
	state_t state_r;
	logic [CNT_W-1:0] cnt_r;
	logic exec_done;
	act_t act_nxt;
	cmd_info_t run_info;
	logic abort;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	cmd_table u_table (
		.code(CMD_CODE),
		.info(info)
	);

	// Properties of the long command now running
	cmd_table u_run_table (
		.code(code_r),
		.info(run_info)
	);

	always_comb begin
		unique case (info.req)
			REQ_ALL: req_met = 1'b1;
			REQ_EN: req_met = OP_CTRL.main_en;
			REQ_EN_TX: req_met = OP_CTRL.main_en & OP_CTRL.tx_en;
			REQ_EN_RX: req_met = OP_CTRL.main_en & OP_CTRL.rx_en;
			REQ_NOT_WU: req_met = ~OP_CTRL.wakeup_mode_bit;
			REQ_NONE: req_met = 1'b0;
			default: req_met = 1'b0;
		endcase
	end

	// New commands are refused while a long one runs, except set default and stop
	assign accept = CMD_VALID & info.known & req_met
		& ((state_r == ST_IDLE) | CMD_CODE == CMD_SET_DEFAULT_A | CMD_CODE == CMD_SET_DEFAULT_B
		| CMD_CODE == CMD_STOP_ALL_A | CMD_CODE == CMD_STOP_ALL_B);

	always_comb begin
		act_nxt = '0;
		if (accept) begin
			unique case (CMD_CODE)
				CMD_SET_DEFAULT_A, CMD_SET_DEFAULT_B: act_nxt.set_default = 1'b1;
				CMD_STOP_ALL_A, CMD_STOP_ALL_B: act_nxt.stop_all = 1'b1;
				CMD_TX_CRC: act_nxt.tx_crc = 1'b1;
				CMD_TX_NOCRC: act_nxt.tx_nocrc = 1'b1;
				CMD_TX_REQA: act_nxt.tx_reqa = 1'b1;
				CMD_TX_WUPA: act_nxt.tx_wupa = 1'b1;
				CMD_FIELD_INIT: act_nxt.field_init = 1'b1;
				CMD_FIELD_RESP: act_nxt.field_resp = 1'b1;
				CMD_GO_SENSE: act_nxt.go_sense = 1'b1;
				CMD_GO_SLEEP: act_nxt.go_sleep = 1'b1;
				CMD_RX_GAIN: act_nxt.rx_gain_reload = 1'b1;
				CMD_ADJ_REG: act_nxt.adjust_reg = 1'b1;
				CMD_CAL_DRV: act_nxt.cal_driver = 1'b1;
				CMD_MEAS_AMP: act_nxt.meas_amp = 1'b1;
				CMD_MEAS_PHASE: act_nxt.meas_phase = 1'b1;
				CMD_CLR_RSSI: act_nxt.clr_rssi = 1'b1;
				CMD_CLR_FIFO: act_nxt.clr_fifo = 1'b1;
				CMD_TRANSPARENT: act_nxt.transparent = 1'b1;
				CMD_CAL_CAP: act_nxt.cal_cap = 1'b1;
				CMD_MEAS_CAP: act_nxt.meas_cap = 1'b1;
				CMD_MEAS_SUPPLY: act_nxt.meas_supply = 1'b1;
				CMD_TMR_GP: act_nxt.tmr_gp = 1'b1;
				CMD_TMR_WAKE: act_nxt.tmr_wake = 1'b1;
				CMD_TMR_MASK: act_nxt.tmr_mask = 1'b1;
				CMD_TMR_NORESP: act_nxt.tmr_noresp = 1'b1;
				CMD_TMR_PP2: act_nxt.tmr_pp2 = 1'b1;
				CMD_TMR_NORESP_STOP: act_nxt.tmr_noresp_stop = 1'b1;
				CMD_TEST_ACCESS: act_nxt.test_access = 1'b1;
				default: act_nxt = '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Strobes and acceptance flags
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ACTION <= '0;
			CMD_ACCEPTED <= 1'b0;
			CMD_REFUSED <= 1'b0;
		end else begin
			ACTION <= act_nxt;
			CMD_ACCEPTED <= accept;
			CMD_REFUSED <= CMD_VALID & ~accept;
		end
	end

	// Chaining permission holds until the frame ends
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			CHAIN_OK <= 1'b0;
		end else if (accept) begin
			CHAIN_OK <= info.chain & ~info.timed;
		end else if (FRAME_END) begin
			CHAIN_OK <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Execution of long commands
	// ------------------------------------------------------------
	assign exec_done = (state_r == ST_EXEC) && (cnt_r == CNT_ONE);

	// Set default and stop both end a running command at once
	assign abort = accept & (act_nxt.set_default | act_nxt.stop_all);

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			code_r <= '0;
		end else if (abort) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (accept && info.timed) begin
						state_r <= ST_EXEC;
						cnt_r <= EXEC_LOAD;
						code_r <= CMD_CODE;
					end
				end
				ST_EXEC: begin
					cnt_r <= cnt_r - CNT_ONE;
					if (exec_done) begin
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Completion interrupt; a stopped command raises none
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			DONE_IRQ <= 1'b0;
			BUSY <= 1'b0;
		end else begin
			DONE_IRQ <= exec_done & run_info.irq & ~abort;
			BUSY <= ~abort & ((state_r == ST_EXEC) ? ~exec_done : (accept & info.timed));
		end
	end

	// Oscillator forced on for amplitude and phase measurements started in power-down
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			OSC_TEMP_EN <= 1'b0;
		end else if (accept && POWER_DOWN && (act_nxt.meas_amp || act_nxt.meas_phase)) begin
			OSC_TEMP_EN <= 1'b1;
		end else if (exec_done || abort) begin
			OSC_TEMP_EN <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Persistent mode state
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N || (accept && act_nxt.set_default)) begin
			RX_MASKED <= 1'b0;
		end else if (accept && CMD_CODE == CMD_MASK_RX) begin
			RX_MASKED <= 1'b1;
		end else if (accept && CMD_CODE == CMD_UNMASK_RX) begin
			RX_MASKED <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N || (accept && act_nxt.set_default)) begin
			AM_MODULATED <= 1'b0;
		end else if (accept && CMD_CODE == CMD_AM_TOGGLE) begin
			AM_MODULATED <= ~AM_MODULATED;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N || (accept && act_nxt.set_default)) begin
			TARGET_SLEEP <= 1'b0;
		end else if (accept && act_nxt.go_sleep) begin
			TARGET_SLEEP <= 1'b1;
		end else if (accept && act_nxt.go_sense) begin
			TARGET_SLEEP <= 1'b0;
		end
	end

	// Second space lasts for the SPI frame, or until I2C stop
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N || (accept && act_nxt.set_default)) begin
			SPACE_B_EN <= 1'b0;
		end else if (accept && CMD_CODE == CMD_SPACE_B) begin
			SPACE_B_EN <= 1'b1;
		end else if (I2C_MODE ? I2C_STOP : FRAME_END) begin
			SPACE_B_EN <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N || (accept && act_nxt.set_default)) begin
			TEST_EN <= 1'b0;
		end else if (accept && act_nxt.test_access) begin
			TEST_EN <= 1'b1;
		end else if (FRAME_END || (I2C_MODE && I2C_STOP)) begin
			TEST_EN <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N || (accept && act_nxt.set_default)) begin
			TRANSPARENT_MODE <= 1'b0;
		end else if (accept && act_nxt.transparent) begin
			TRANSPARENT_MODE <= 1'b1;
		end else if (FRAME_END) begin
			TRANSPARENT_MODE <= 1'b0;
		end
	end

endmodule // nfc_direct_command_decoder

// *** test/nfc_direct_command_decoder_props.sv ***
// Purpose: Port-level checks of the direct command decoder
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every decoder instance
module nfc_cmd_props
	import cmd_decoder_pkg::*;
#(
	parameter int EXEC_CYCLES = EXEC_CYCLES_DEF
)
(
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_CODE,
	input wire op_ctrl_t OP_CTRL,
	input wire logic POWER_DOWN,
	input wire logic FRAME_END,
	input wire act_t ACTION,
	input wire logic CMD_ACCEPTED,
	input wire logic CMD_REFUSED,
	input wire logic CHAIN_OK,
	input wire logic BUSY,
	input wire logic DONE_IRQ,
	input wire logic OSC_TEMP_EN,
	input wire logic RX_MASKED
);
	// ------
	// Checks
	// ------
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	logic [15:0] busy_cnt_r;
	// Length of the current busy stretch
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N || !BUSY)
			busy_cnt_r <= 16'h0;
		else
			busy_cnt_r <= busy_cnt_r + 16'h1;
	end
	sequence take(logic [7:0] c);
		CMD_VALID && CMD_CODE == c;
	endsequence
	sequence go(logic [7:0] c, logic ok);
		CMD_VALID && !BUSY && ok && CMD_CODE == c;
	endsequence
	sequence long_go;
		CMD_ACCEPTED && (ACTION.field_init || ACTION.field_resp || ACTION.meas_amp
			|| ACTION.meas_phase || ACTION.adjust_reg || ACTION.cal_cap
			|| ACTION.meas_cap || ACTION.meas_supply);
	endsequence
	chk_refuse_quiet: assert property (CMD_REFUSED |-> ACTION == '0 && !CMD_ACCEPTED)
		else $error("refused command acted");
	chk_valid_answer: assert property (CMD_VALID |=> CMD_ACCEPTED || CMD_REFUSED)
		else $error("command got no answer");
	chk_no_stray: assert property (!$past(CMD_VALID) |-> !CMD_ACCEPTED && !CMD_REFUSED)
		else $error("answer without command");
	chk_rsvd_refused: assert property (take(8'hFA) |=> CMD_REFUSED)
		else $error("reserved code accepted");
	chk_default_now: assert property (take(8'hC0) |=> ACTION.set_default && !CHAIN_OK && !DONE_IRQ)
		else $error("set default wrong");
	chk_fifo_chain: assert property (go(8'hDB, OP_CTRL.main_en && !FRAME_END)
		|=> ACTION.clr_fifo && CHAIN_OK)
		else $error("fifo clear wrong");
	chk_main_needed: assert property (go(8'hC4, !OP_CTRL.main_en) |=> CMD_REFUSED)
		else $error("transmit without enable");
	chk_rx_needed: assert property (go(8'hCE, !OP_CTRL.rx_en) |=> CMD_REFUSED)
		else $error("sleep without rx enable");
	chk_wake_refused: assert property (go(8'hE1, OP_CTRL.wakeup_mode_bit) |=> CMD_REFUSED)
		else $error("wake timer in wake-up mode");
	chk_osc_pd: assert property (go(8'hD3, POWER_DOWN) |=> OSC_TEMP_EN && BUSY)
		else $error("no oscillator in power-down");
	chk_mask_any: assert property (go(8'hD0, 1'h1) |=> RX_MASKED)
		else $error("receive not masked");
	chk_long_busy: assert property (long_go |-> BUSY && !CHAIN_OK)
		else $error("long command not busy");
	chk_done_time: assert property (DONE_IRQ |-> !BUSY && busy_cnt_r == EXEC_CYCLES)
		else $error("completion at wrong time");
	chk_stop_idle: assert property (CMD_VALID && CMD_CODE == 8'hC2 && OP_CTRL.main_en
		|=> !BUSY && !DONE_IRQ)
		else $error("stop left command running");
endmodule // nfc_cmd_props

bind nfc_direct_command_decoder nfc_cmd_props #(.EXEC_CYCLES(EXEC_CYCLES)) u_props (
	.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE),
	.OP_CTRL(OP_CTRL), .POWER_DOWN(POWER_DOWN), .FRAME_END(FRAME_END), .ACTION(ACTION),
	.CMD_ACCEPTED(CMD_ACCEPTED), .CMD_REFUSED(CMD_REFUSED), .CHAIN_OK(CHAIN_OK),
	.BUSY(BUSY), .DONE_IRQ(DONE_IRQ), .OSC_TEMP_EN(OSC_TEMP_EN), .RX_MASKED(RX_MASKED)
);

// *** test/nfc_cmd_host.sv ***
// Purpose: Host model issuing direct command bytes
// Assumes: Strobes change at the falling clock edge
// Notes: Code lines carry the inverse of the last byte between strobes
module nfc_cmd_host (
	input wire logic clk,
	input wire logic done_irq,
	output logic cmd_valid,
	output logic [7:0] cmd_code
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_valid = 1'h0;
		cmd_code = 8'h00;
	end
	// One-cycle strobe; further bytes may follow in the same frame
	task automatic send(input logic [7:0] code);
		@(negedge clk);
		cmd_valid = 1'h1;
		cmd_code = code;
		@(negedge clk);
		cmd_valid = 1'h0;
		cmd_code = ~code;
	endtask
	// Stay off the interface until completion, bounded
	task automatic wait_done(input int lim, output int n);
		n = 0;
		while (done_irq !== 1'h1 && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask
endmodule // nfc_cmd_host

// *** test/test_nfc_direct_command_decoder.sv ***
// Purpose: Self-checking bench of the direct command decoder
// Assumes: Inputs driven at the falling edge
// Notes: Busy time shortened through EXEC_CYCLES
module test_nfc_direct_command_decoder
	import cmd_decoder_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int EXEC = 6;
	localparam logic [7:0] SHORT [24] = '{8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hCD,
		8'hCE, 8'hD0, 8'hD1, 8'hD2, 8'hD5, 8'hD8, 8'hDA, 8'hDB, 8'hDC, 8'hE0, 8'hE1, 8'hE2,
		8'hE3, 8'hE4, 8'hE8, 8'hFB, 8'hFC};
	localparam logic [7:0] LONG [8] = '{8'hC8, 8'hC9, 8'hD3, 8'hD6, 8'hD9, 8'hDD, 8'hDE, 8'hDF};
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	op_ctrl_t op_ctrl = '0;
	logic pd = 1'h0, i2c = 1'h0, stop = 1'h0, fend = 1'h0;
	logic cmd_valid, busy, done, acc, ref_n, chain, osc, rxm, am, slp, spb, tst, trn;
	logic [7:0] cmd_code;
	act_t action;
	int err_total = 0, cmp_count = 0, cyc = 0;

	nfc_direct_command_decoder #(.EXEC_CYCLES(EXEC)) dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
		.CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .OP_CTRL(op_ctrl), .POWER_DOWN(pd),
		.I2C_MODE(i2c), .I2C_STOP(stop), .FRAME_END(fend), .ACTION(action),
		.CMD_ACCEPTED(acc), .CMD_REFUSED(ref_n), .CHAIN_OK(chain), .BUSY(busy),
		.DONE_IRQ(done), .OSC_TEMP_EN(osc), .RX_MASKED(rxm), .AM_MODULATED(am),
		.TARGET_SLEEP(slp), .SPACE_B_EN(spb), .TEST_EN(tst), .TRANSPARENT_MODE(trn));
	nfc_cmd_host host (.clk(sys_clk), .done_irq(done), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code));

	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			conclude();
		end
	end
	// ------
	// Helpers
	// ------
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: flag", $time);
		end
	endtask
	task automatic cmp_act(input act_t got, input act_t exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: action", $time);
		end
	endtask
	task automatic pulse(input logic on_stop);
		@(negedge sys_clk);
		if (on_stop)
			stop = 1'h1;
		else
			fend = 1'h1;
		@(negedge sys_clk);
		stop = 1'h0;
		fend = 1'h0;
	endtask
	task automatic conclude();
		if (err_total == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ------
	// Scenarios
	// ------
	task automatic t_refuse();
		logic a;
		op_ctrl = 4'h0;
		foreach (SHORT[i]) begin
			a = SHORT[i] inside {8'hD0, 8'hD1, 8'hE1, 8'hFB, 8'hFC};
			host.send(SHORT[i]);
			cmp_bit(acc, a);
			cmp_bit(ref_n, !a);
			if (!a) cmp_act(action, '0);
		end
		op_ctrl = 4'hA;
		host.send(8'hCE);
		cmp_bit(ref_n, 1'h1);
		op_ctrl = 4'hC;
		host.send(8'hC6);
		cmp_bit(ref_n, 1'h1);
		op_ctrl = 4'hF;
		host.send(8'hE1);
		cmp_bit(ref_n, 1'h1);
		host.send(8'hFA);
		cmp_bit(ref_n, 1'h1);
		host.send(8'h00);
		cmp_act(action, '0);
	endtask
	task automatic t_levels();
		act_t e;
		e = '0;
		e.set_default = 1'h1;
		op_ctrl = 4'hE;
		host.send(8'hD0);
		cmp_bit(rxm, 1'h1);
		host.send(8'hD1);
		cmp_bit(rxm, 1'h0);
		host.send(8'hD2);
		cmp_bit(am, 1'h1);
		host.send(8'hD2);
		cmp_bit(am, 1'h0);
		host.send(8'hCE);
		cmp_bit(slp, 1'h1);
		host.send(8'hCD);
		cmp_bit(slp, 1'h0);
		host.send(8'hCE);
		host.send(8'hDC);
		cmp_bit(trn, 1'h1);
		host.send(8'hFC);
		cmp_bit(tst, 1'h1);
		pulse(1'h0);
		cmp_bit(chain | trn | tst, 1'h0);
		i2c = 1'h1;
		host.send(8'hFB);
		pulse(1'h0);
		cmp_bit(spb, 1'h1);
		host.send(8'hFC);
		pulse(1'h1);
		cmp_bit(spb | tst, 1'h0);
		i2c = 1'h0;
		host.send(8'hFB);
		host.send(8'hC0);
		cmp_act(action, e);
		cmp_bit(spb | slp | chain | done, 1'h0);
	endtask
	task automatic t_short();
		act_t e;
		e = '0;
		e.clr_fifo = 1'h1;
		foreach (SHORT[i]) begin
			host.send(SHORT[i]);
			cmp_bit(acc, 1'h1);
			cmp_bit(chain, !(SHORT[i] inside {8'hD5, 8'hD8, 8'hDC}));
			cmp_bit(done | busy, 1'h0);
		end
		host.send(8'hDB);
		cmp_act(action, e);
	endtask
	task automatic t_long();
		int n;
		pd = 1'h1;
		foreach (LONG[i]) begin
			host.send(LONG[i]);
			cmp_bit(busy & !chain, 1'h1);
			cmp_bit(osc, LONG[i] inside {8'hD3, 8'hD9});
			host.wait_done(EXEC + 4, n);
			cmp_bit(n == EXEC, 1'h1);
		end
		pd = 1'h0;
	endtask
	task automatic t_abort();
		int n;
		host.send(8'hC8);
		host.send(8'hDB);
		cmp_bit(ref_n, 1'h1);
		host.send(8'hC2);
		cmp_bit(acc, 1'h1);
		cmp_bit(busy, 1'h0);
		host.wait_done(EXEC + 2, n);
		cmp_bit(n == EXEC + 2 && !busy, 1'h1);
		host.send(8'hC9);
		host.send(8'hD3);
		cmp_bit(ref_n, 1'h1);
		host.wait_done(EXEC + 2, n);
		cmp_bit(n == EXEC - 2, 1'h1);
	endtask
	initial begin
		repeat (10) @(negedge sys_clk);
		cmp_bit(busy | chain | acc, 1'h0);
		cmp_act(action, '0);
		rst_n = 1'h1;
		t_refuse();
		t_levels();
		t_short();
		t_long();
		t_abort();
		conclude();
	end
endmodule // test_nfc_direct_command_decoder
